// ===== common/fps_pkg.sv
// constants, carriers and state codes shared by the flash command/status block
package fps_pkg;
    // special function register addresses
    localparam logic [7:0] FPS_ADDR_CMD_STATUS = 8'he4;
    localparam logic [7:0] FPS_ADDR_DATA_PORT = 8'he5;
    localparam logic [7:0] FPS_ADDR_LOW = 8'he6;
    localparam logic [7:0] FPS_ADDR_HIGH = 8'he7;
    // command codes written to the command/status register
    localparam logic [7:0] FPS_CMD_LOAD = 8'h00;
    localparam logic [7:0] FPS_CMD_ERASE_PROGRAM = 8'h68;
    // status field positions and reset values
    localparam int FPS_BIT_OI = 0;
    localparam int FPS_BIT_SV = 1;
    localparam int FPS_BIT_HVE = 2;
    localparam int FPS_BIT_HVA = 3;
    localparam int FPS_FLAG_W = 4;
    localparam logic [3:0] FPS_STATUS_RST = 4'h0;
    localparam logic [3:0] FPS_RSVD_VALUE = 4'h0;
    localparam logic [7:0] FPS_ADDR_RST = 8'h00;
    localparam logic [7:0] FPS_RDATA_RST = 8'h00;
    // page register geometry
    localparam int FPS_PAGE_BYTES = 16;
    localparam int FPS_IDX_W = 4;
    localparam logic [3:0] FPS_IDX_STEP = 4'h1;
    // erase-program duration
    localparam int FPS_CLK_KHZ = 125000;
    localparam int FPS_EP_TIME_US = 4000;
    localparam int FPS_EP_CYCLES = FPS_EP_TIME_US * (FPS_CLK_KHZ / 1000);
    localparam int FPS_CNT_W = 20;
    localparam logic [19:0] FPS_CNT_RST = 20'h00000;
    localparam logic [19:0] FPS_CNT_STEP = 20'h00001;

    // cpu special function register access, one cycle per request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fps_sfr_req_s;

    // status flags in register bit order 3..0
    typedef struct packed {
        logic hv_abort_flag;
        logic hv_error_flag;
        logic sv;
        logic oi;
    } fps_flags_s;

    typedef enum logic [1:0] {
        FPS_ST_IDLE = 2'b01,
        FPS_ST_RUN = 2'b10
    } fps_state_e;
endpackage

// ===== tb/fps_top_tb_top.sv
// self-checking testbench for the flash command/status block
module fps_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fps_pkg::*;
    localparam int EPC = 20;
    logic MCLK = 0, RST = 1, IRQ_PENDING = 0, BROWNOUT = 0, BOD_DISABLED = 0;
    logic HV_FAULT = 0, PAGE_SECURED = 0, CPU_IDLE, FL_HV_ON, FL_COMMIT, rd_d = 0;
    fps_sfr_req_s SFR_REQ = '0;
    logic [7:0] SFR_RDATA;
    logic [11:0] FL_PAGE_ADDR, pa;
    logic [FPS_PAGE_BYTES*8-1:0] FL_PAGE_DATA, exp_data;
    logic [FPS_PAGE_BYTES-1:0] FL_UPDATE_MASK, exp_mask;
    logic [7:0] exp_q[$];
    int mismatches = 0, check_count = 0;

    fps_top #(.EP_CYCLES(EPC)) u_dut (
        .MCLK(MCLK), .RST(RST), .SFR_REQ(SFR_REQ), .IRQ_PENDING(IRQ_PENDING),
        .BROWNOUT(BROWNOUT), .BOD_DISABLED(BOD_DISABLED), .HV_FAULT(HV_FAULT),
        .PAGE_SECURED(PAGE_SECURED), .SFR_RDATA(SFR_RDATA), .CPU_IDLE(CPU_IDLE),
        .FL_HV_ON(FL_HV_ON), .FL_COMMIT(FL_COMMIT), .FL_PAGE_ADDR(FL_PAGE_ADDR),
        .FL_PAGE_DATA(FL_PAGE_DATA), .FL_UPDATE_MASK(FL_UPDATE_MASK)
    );

    // 125 MHz clock
    initial begin
        forever #4 MCLK = ~MCLK;
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s seen %0h exp %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one-cycle register request, driven just after the edge
    task automatic sfr(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        #1 SFR_REQ = {wr, rd, a, d};
        @(posedge MCLK);
        #1 SFR_REQ = '0;
    endtask

    // read with its expected value noted for the monitor
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        sfr(1'b0, 1'b1, a, 8'h00);
    endtask

    // erase-program with an optional event pulse on the fifth cycle of the run
    task automatic run_ep(input logic [2:0] pat, output int hi, output int commits);
        commits = 0;
        sfr(1'b1, 1'b0, FPS_ADDR_CMD_STATUS, FPS_CMD_ERASE_PROGRAM);
        check(CPU_IDLE, 1'b1, "cpu idle entered");
        check(FL_HV_ON, 1'b1, "hv on");
        sfr(1'b1, 1'b0, FPS_ADDR_LOW, 8'hff);
        check(FL_PAGE_ADDR, pa, "write during run ignored");
        hi = 2;
        while (CPU_IDLE === 1'b1 && hi < 1000) begin
            @(posedge MCLK);
            #1;
            hi++;
            {IRQ_PENDING, BROWNOUT, HV_FAULT} = (hi == 4) ? pat : 3'b000;
            if (FL_COMMIT === 1'b1) commits++;
        end
        check(FL_HV_ON, 1'b0, "hv off after run");
        @(posedge MCLK);
        #1 check(FL_COMMIT, 1'b0, "commit is one pulse");
    endtask

    // read data appears the cycle after each read and is compared with the oldest note
    always @(posedge MCLK) begin
        rd_d <= SFR_REQ.rd;
        if (rd_d && exp_q.size() > 0) check(SFR_RDATA, exp_q.pop_front(), "read data");
    end

    // watchdog against a hang
    initial begin
        #50000;
        mismatches++;
        summarize();
    end

    // main sequence
    initial begin
        int hi, commits, idx;
        logic [7:0] lo, ah, d;
        logic [2:0] pats[3] = '{3'b100, 3'b010, 3'b001};
        logic [7:0] flags[3] = '{8'h09, 8'h08, 8'h04};
        hi = $urandom(97);
        repeat (2) @(posedge MCLK);
        #1 RST = 0;
        rd_chk(FPS_ADDR_CMD_STATUS, 8'h00);
        rd_chk(FPS_ADDR_DATA_PORT, 8'h00);
        rd_chk(8'h3c, 8'h00);
        // load three bytes starting at index 14 so the index wraps
        sfr(1'b1, 1'b0, FPS_ADDR_CMD_STATUS, FPS_CMD_LOAD);
        lo = {4'($urandom), 4'he};
        ah = 8'($urandom);
        pa = {ah, lo[7:4]};
        sfr(1'b1, 1'b0, FPS_ADDR_LOW, lo);
        sfr(1'b1, 1'b0, FPS_ADDR_HIGH, ah);
        exp_data = '0;
        exp_mask = '0;
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            idx = (14 + i) % 16;
            exp_data[idx*8 +: 8] = d;
            exp_mask[idx] = 1'b1;
            sfr(1'b1, 1'b0, FPS_ADDR_DATA_PORT, d);
        end
        check(FL_PAGE_DATA, exp_data, "page data");
        check(FL_UPDATE_MASK, exp_mask, "update mask");
        check(FL_PAGE_ADDR, pa, "page address");
        // address registers read back; the low index wrapped from 14 to 1
        rd_chk(FPS_ADDR_HIGH, ah);
        rd_chk(FPS_ADDR_LOW, {lo[7:4], 4'h1});
        // undisturbed cycle completes once
        run_ep(3'b000, hi, commits);
        check(hi, EPC, "run length");
        check(commits, 1, "commit count");
        rd_chk(FPS_ADDR_CMD_STATUS, 8'h00);
        // interrupt, brown-out and generator fault each abort the run
        for (int k = 0; k < 3; k++) begin
            run_ep(pats[k], hi, commits);
            check(hi, 5, "abort next cycle");
            check(commits, 0, "no commit on abort");
            rd_chk(FPS_ADDR_CMD_STATUS, flags[k]);
        end
        sfr(1'b1, 1'b0, FPS_ADDR_CMD_STATUS, 8'h6c);
        rd_chk(FPS_ADDR_CMD_STATUS, 8'h00);
        // events while no cycle runs leave the status alone
        {IRQ_PENDING, BROWNOUT, HV_FAULT} = 3'b111;
        rd_chk(FPS_ADDR_CMD_STATUS, 8'h00);
        {IRQ_PENDING, BROWNOUT, HV_FAULT} = 3'b000;
        // refused starts: secured page, then detector off
        for (int k = 0; k < 2; k++) begin
            {PAGE_SECURED, BOD_DISABLED} = (k == 0) ? 2'b10 : 2'b01;
            sfr(1'b1, 1'b0, FPS_ADDR_CMD_STATUS, FPS_CMD_ERASE_PROGRAM);
            check(CPU_IDLE, 1'b0, "refused start");
            rd_chk(FPS_ADDR_CMD_STATUS, (k == 0) ? 8'h02 : 8'h08);
        end
        {PAGE_SECURED, BOD_DISABLED} = 2'b00;
        // load command empties the page
        sfr(1'b1, 1'b0, FPS_ADDR_CMD_STATUS, FPS_CMD_LOAD);
        check(FL_UPDATE_MASK, 16'h0000, "mask cleared");
        check(FL_PAGE_DATA, 128'h0, "data cleared");
        rd_chk(FPS_ADDR_CMD_STATUS, 8'h00);
        repeat (2) @(posedge MCLK);
        check(exp_q.size(), 0, "reads left unanswered");
        summarize();
    end
endmodule

// ===== verilog/fps_page_reg.sv
// sixteen-byte page register with one update flag per byte
module fps_page_reg (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic clear,
    input wire logic load,
    input wire logic [fps_pkg::FPS_IDX_W-1:0] idx,
    input wire logic [7:0] data,
    output logic [fps_pkg::FPS_PAGE_BYTES*8-1:0] page_data,
    output logic [fps_pkg::FPS_PAGE_BYTES-1:0] update_mask
);
    import fps_pkg::*;

    // one storage byte and flag per location; clear wins over a load
    genvar g;
    generate
        for (g = 0; g < FPS_PAGE_BYTES; g++) begin : g_byte
            wire hit = load && (idx == FPS_IDX_W'(g));
            always_ff @(posedge MCLK or posedge RST) begin
                if (RST) begin
                    page_data[g*8 +: 8] <= 8'h00;
                    update_mask[g] <= 1'b0;
                end else if (clear) begin
                    page_data[g*8 +: 8] <= 8'h00;
                    update_mask[g] <= 1'b0;
                end else if (hit) begin
                    page_data[g*8 +: 8] <= data;
                    update_mask[g] <= 1'b1;
                end
            end
        end
    endgenerate

    AST_LOAD_CLEARS: assert property (@(posedge MCLK) disable iff (RST)
        clear |=> (update_mask == '0) && (page_data == '0))
        else $error("page register not cleared by load command");
    AST_BYTE_LOADED: assert property (@(posedge MCLK) disable iff (RST)
        load && !clear |=> update_mask[$past(idx)] && (page_data[$past(idx)*8 +: 8] == $past(data)))
        else $error("page byte or update flag not stored");
endmodule

// ===== verilog/fps_top.sv
// flash command/status register with page loading and erase-program sequencing
// Notes on behaviour
// - interrupt or brown-out during cycle sets abort
// - starting with brown-out detector off sets abort
// - generator fault during operation sets error flag
// - secured page program attempt sets violation flag
// - interrupt aborts cycle, sets interrupted flag
// - command write clears flags; reads give status
// - load command clears page bytes and flags
// - erase-program runs 4 ms, cpu held idle
module fps_top #(
    parameter int EP_CYCLES = fps_pkg::FPS_EP_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire fps_pkg::fps_sfr_req_s SFR_REQ,
    input wire logic IRQ_PENDING,
    input wire logic BROWNOUT,
    input wire logic BOD_DISABLED,
    input wire logic HV_FAULT,
    input wire logic PAGE_SECURED,
    output logic [7:0] SFR_RDATA,
    output logic CPU_IDLE,
    output logic FL_HV_ON,
    output logic FL_COMMIT,
    output logic [11:0] FL_PAGE_ADDR,
    output logic [fps_pkg::FPS_PAGE_BYTES*8-1:0] FL_PAGE_DATA,
    output logic [fps_pkg::FPS_PAGE_BYTES-1:0] FL_UPDATE_MASK
);
    import fps_pkg::*;

    localparam logic [FPS_CNT_W-1:0] EP_LAST = FPS_CNT_W'(EP_CYCLES - 1);

    // address match of one request against one register
    function automatic logic sfr_hit(input fps_sfr_req_s req, input logic [7:0] addr);
        sfr_hit = (req.addr == addr);
    endfunction

    fps_state_e state_reg;
    fps_state_e state_next;
    fps_flags_s flags_reg;
    fps_flags_s flags_next;
    fps_flags_s flags_set;
    logic [FPS_CNT_W-1:0] cnt_reg;
    logic [FPS_CNT_W-1:0] cnt_next;
    logic [7:0] addr_low_reg;
    logic [7:0] addr_low_next;
    logic [7:0] addr_high_reg;
    logic [7:0] addr_high_next;
    logic [7:0] rdata_next;

    // request decode; writes are only taken while no cycle runs
    wire idle = (state_reg == FPS_ST_IDLE);
    wire run = (state_reg == FPS_ST_RUN);
    wire wr_ok = SFR_REQ.wr && idle;
    wire cmd_wr = wr_ok && sfr_hit(SFR_REQ, FPS_ADDR_CMD_STATUS);
    wire data_wr = wr_ok && sfr_hit(SFR_REQ, FPS_ADDR_DATA_PORT);
    wire low_wr = wr_ok && sfr_hit(SFR_REQ, FPS_ADDR_LOW);
    wire high_wr = wr_ok && sfr_hit(SFR_REQ, FPS_ADDR_HIGH);
    wire load_cmd = cmd_wr && (SFR_REQ.wdata == FPS_CMD_LOAD);
    wire ep_cmd = cmd_wr && (SFR_REQ.wdata == FPS_CMD_ERASE_PROGRAM);
    wire ep_refuse = ep_cmd && (PAGE_SECURED || BOD_DISABLED);
    wire ep_go = ep_cmd && !ep_refuse;

    // events seen while the cycle runs; any of them ends it early
    wire irq_ev = run && IRQ_PENDING;
    wire bo_ev = run && BROWNOUT;
    wire hv_ev = run && HV_FAULT;
    wire abort = irq_ev || bo_ev || hv_ev;
    wire done = run && !abort && (cnt_reg == EP_LAST);

    // flag set terms
    assign flags_set.hv_abort_flag = irq_ev || bo_ev || (ep_cmd && BOD_DISABLED);
    assign flags_set.hv_error_flag = hv_ev;
    assign flags_set.sv = ep_cmd && PAGE_SECURED;
    assign flags_set.oi = irq_ev;

    // a command write clears the flags, a same-cycle event still sets
    assign flags_next = (cmd_wr ? fps_flags_s'(FPS_STATUS_RST) : flags_reg) | flags_set;

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FPS_ST_IDLE: begin
                if (ep_go) begin
                    state_next = FPS_ST_RUN;
                end
            end
            FPS_ST_RUN: begin
                if (abort || done) begin
                    state_next = FPS_ST_IDLE;
                end
            end
            default: begin
                state_next = FPS_ST_IDLE;
            end
        endcase
    end

    // cycle timer counts from zero to the last cycle of the run
    assign cnt_next = (run && !abort && !done) ? cnt_reg + FPS_CNT_STEP : FPS_CNT_RST;

    // address registers; a data write steps the low nibble and wraps inside the page
    assign addr_low_next = low_wr ? SFR_REQ.wdata :
        data_wr ? {addr_low_reg[7:4], addr_low_reg[3:0] + FPS_IDX_STEP} : addr_low_reg;
    assign addr_high_next = high_wr ? SFR_REQ.wdata : addr_high_reg;

    // read data; status sits in the low bits, reserved bits read zero
    assign rdata_next = !SFR_REQ.rd ? FPS_RDATA_RST :
        sfr_hit(SFR_REQ, FPS_ADDR_CMD_STATUS) ? {FPS_RSVD_VALUE, flags_reg} :
        sfr_hit(SFR_REQ, FPS_ADDR_LOW) ? addr_low_reg :
        sfr_hit(SFR_REQ, FPS_ADDR_HIGH) ? addr_high_reg : FPS_RDATA_RST;

    // state, flags and counter
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_reg <= FPS_ST_IDLE;
            flags_reg <= fps_flags_s'(FPS_STATUS_RST);
            cnt_reg <= FPS_CNT_RST;
        end else begin
            state_reg <= state_next;
            flags_reg <= flags_next;
            cnt_reg <= cnt_next;
        end
    end

    // address registers and registered outputs
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            addr_low_reg <= FPS_ADDR_RST;
            addr_high_reg <= FPS_ADDR_RST;
            SFR_RDATA <= FPS_RDATA_RST;
            CPU_IDLE <= 1'b0;
            FL_HV_ON <= 1'b0;
            FL_COMMIT <= 1'b0;
            FL_PAGE_ADDR <= 12'h000;
        end else begin
            addr_low_reg <= addr_low_next;
            addr_high_reg <= addr_high_next;
            SFR_RDATA <= rdata_next;
            CPU_IDLE <= (state_next == FPS_ST_RUN);
            FL_HV_ON <= (state_next == FPS_ST_RUN);
            FL_COMMIT <= done;
            FL_PAGE_ADDR <= {addr_high_next, addr_low_next[7:4]};
        end
    end

    // page register, cleared by the load command and filled through the data port
    fps_page_reg u_page (
        .MCLK(MCLK),
        .RST(RST),
        .clear(load_cmd),
        .load(data_wr),
        .idx(addr_low_reg[FPS_IDX_W-1:0]),
        .data(SFR_REQ.wdata),
        .page_data(FL_PAGE_DATA),
        .update_mask(FL_UPDATE_MASK)
    );

    AST_IRQ_ABORT: assert property (@(posedge MCLK) disable iff (RST)
        run && IRQ_PENDING |=> flags_reg.oi && flags_reg.hv_abort_flag && idle && !CPU_IDLE && !FL_COMMIT)
        else $error("interrupt did not abort the cycle with flags set");
    AST_BROWNOUT_ABORT: assert property (@(posedge MCLK) disable iff (RST)
        run && BROWNOUT && !IRQ_PENDING |=> flags_reg.hv_abort_flag && !flags_reg.oi && idle)
        else $error("brown-out did not set the abort flag");
    AST_BOD_OFF_START: assert property (@(posedge MCLK) disable iff (RST)
        ep_cmd && BOD_DISABLED |=> flags_reg.hv_abort_flag && idle && !CPU_IDLE)
        else $error("start with detector off not flagged");
    AST_HV_FAULT: assert property (@(posedge MCLK) disable iff (RST)
        run && HV_FAULT |=> flags_reg.hv_error_flag && idle)
        else $error("generator fault not flagged");
    AST_SECURED: assert property (@(posedge MCLK) disable iff (RST)
        ep_cmd && PAGE_SECURED && !BOD_DISABLED |=> flags_reg == 4'b0010 && idle)
        else $error("secured page attempt not flagged");
    AST_CMD_CLEARS: assert property (@(posedge MCLK) disable iff (RST)
        cmd_wr && !ep_cmd |=> flags_reg == 4'h0)
        else $error("command write did not clear the status");
    AST_READ_STATUS: assert property (@(posedge MCLK) disable iff (RST)
        SFR_REQ.rd && sfr_hit(SFR_REQ, FPS_ADDR_CMD_STATUS) |=> SFR_RDATA[3:0] == $past(flags_reg))
        else $error("status read returned wrong flags");
    AST_RSVD_ZERO: assert property (@(posedge MCLK) disable iff (RST)
        SFR_REQ.rd && sfr_hit(SFR_REQ, FPS_ADDR_CMD_STATUS) |=> SFR_RDATA[7:4] == 4'h0)
        else $error("reserved status bits not zero");
    AST_EP_LENGTH: assert property (@(posedge MCLK) disable iff (RST)
        $fell(run) && !$past(abort) |-> FL_COMMIT && ($past(cnt_reg) == EP_LAST))
        else $error("erase-program cycle ended at the wrong time");
    AST_CPU_HELD: assert property (@(posedge MCLK) disable iff (RST)
        ep_go |=> run && CPU_IDLE && FL_HV_ON && flags_reg == 4'h0)
        else $error("cpu not held idle at cycle start");
endmodule
